/* common/port_routing_params.svh */
// register offsets, field masks, bit positions and reset values
// Behaviour
// - reserved bits ignore writes and read zero
// - reads sampled on the clock edge
// - writable bits other than the routing register accept writes at any time
// - routing register: once normal, anytime special
// - can pins on j0/j1 or s0/s2
// - i2c lines on t0/t1 or j0/j1
// - second serial on t5/t4 or t1/t0
// - link code 000: internal serial-transceiver only
// - link code 001: data bit drives transceiver
// - link code 100: internal plus two probe pins
// - link code 110: all four signals external
// - serial transmit reaches pins only when enabled
// - transceiver outputs reach pins only when enabled
`ifndef PORT_ROUTING_PARAMS_SVH
`define PORT_ROUTING_PARAMS_SVH
`define ADDR_W 10
`define OFS_ROUTE 10'h200
`define OFS_S_OUT 10'h2d0
`define OFS_S_IN 10'h2d1
`define OFS_S_DIR 10'h2d2
`define OFS_S_PULL_EN 10'h2d3
`define OFS_S_PULL_POL 10'h2d4
`define OFS_S_IRQ_EN 10'h2d6
`define OFS_S_IRQ_FLAG 10'h2d7
`define OFS_S_OD 10'h2df
`define OFS_P_OUT 10'h2f0
`define OFS_P_IN 10'h2f1
`define OFS_P_DIR 10'h2f2
`define OFS_P_PULL_EN 10'h2f3
`define OFS_P_PULL_POL 10'h2f4
`define OFS_P_IRQ_EN 10'h2f6
`define OFS_P_IRQ_FLAG 10'h2f7
`define OFS_P_OCP_EN 10'h2f9
`define OFS_P_OC_IE 10'h2fa
`define OFS_P_OC_FLAG 10'h2fb
`define OFS_P_RDR 10'h2fd
`define OFS_J_OUT 10'h310
`define OFS_J_IN 10'h311
`define OFS_J_DIR 10'h312
`define OFS_J_PULL_EN 10'h313
`define OFS_J_PULL_POL 10'h314
`define OFS_J_OD 10'h31f
`define OFS_L_IN 10'h331
`define OFS_L_PULL_POL 10'h334
`define OFS_L_IRQ_EN 10'h336
`define OFS_L_IRQ_FLAG 10'h337
`define OFS_L_DIEN 10'h33c
`define OFS_L_PORT_L_TEST_ACCESS_CONTROL 10'h33d
`define OFS_L_PORT_L_INPUT_ROUTE 10'h33e
`define OFS_INT_STAT 10'h3f0
`define OFS_INT_MASK 10'h3f1
`define OFS_TXBIT 10'h3f2
`define MASK_S 8'h0f
`define MASK_P 8'hff
`define MASK_J 8'h03
`define MASK_L 8'h01
`define MASK_OC 8'haa
`define MASK_PORT_L_TEST_ACCESS_CONTROL 8'hf8
`define MASK_PORT_L_INPUT_ROUTE 8'h03
`define MASK_ROUTE 8'h3f
`define MASK_INT 8'h1f
`define INT_REFUSED 0
`define INT_PORT_S 1
`define INT_PORT_P 2
`define INT_PORT_L 3
`define INT_OVERCUR 4
`define RST_PORT 8'h00
`define RST_ROUTE 8'h00
`define RST_INT 8'h00
`endif

/* common/port_routing_pkg.sv */
// types shared by the register bank and the routing mux
package port_routing_pkg;
  typedef enum logic [4:0] {
    RI_S_OUT = 5'h00, RI_S_DIR = 5'h01, RI_S_PULL_EN = 5'h02,
    RI_S_PULL_POL = 5'h03, RI_S_IRQ_EN = 5'h04, RI_S_IRQ_FLAG = 5'h05,
    RI_S_OD = 5'h06, RI_P_OUT = 5'h07, RI_P_DIR = 5'h08,
    RI_P_PULL_EN = 5'h09, RI_P_PULL_POL = 5'h0a, RI_P_IRQ_EN = 5'h0b,
    RI_P_IRQ_FLAG = 5'h0c, RI_P_OCP_EN = 5'h0d, RI_P_OC_IE = 5'h0e,
    RI_P_OC_FLAG = 5'h0f, RI_P_RDR = 5'h10, RI_J_OUT = 5'h11,
    RI_J_DIR = 5'h12, RI_J_PULL_EN = 5'h13, RI_J_PULL_POL = 5'h14,
    RI_J_OD = 5'h15, RI_L_PULL_POL = 5'h16, RI_L_IRQ_EN = 5'h17,
    RI_L_IRQ_FLAG = 5'h18, RI_L_DIEN = 5'h19, RI_L_PORT_L_TEST_ACCESS_CONTROL = 5'h1a,
    RI_L_PORT_L_INPUT_ROUTE = 5'h1b
  } reg_idx_t;
  typedef enum logic [1:0] {
    LINK_INTERNAL = 2'b00,
    LINK_DIRECT = 2'b01,
    LINK_PROBE = 2'b10,
    LINK_CONFORM = 2'b11
  } link_mode_t;
  typedef struct packed {
    logic [1:0] rsv;
    logic can_route_select;
    logic i2c_route_select;
    logic second_serial_route_select;
    logic [2:0] serial_lin_link_route;
  } route_t;
  // t holds port_t_pin0, pin1, pin4, pin5 in bits 0..3
  typedef struct packed {
    logic [3:0] s;
    logic [7:0] p;
    logic [1:0] j;
    logic [3:0] t;
  } pad_vec_t;
  typedef struct packed {
    logic can_tx_out;
    logic i2c_data_low;
    logic i2c_clock_low;
    logic second_serial_tx;
    logic serial_tx_out;
    logic transceiver_rx_output;
    logic transceiver_dominant_signal;
  } periph_out_t;
  typedef struct packed {
    logic can_rx_in;
    logic i2c_data_line;
    logic i2c_clock_line;
    logic second_serial_rx;
    logic serial_rx_in;
    logic transceiver_tx_input;
  } periph_in_t;
  typedef struct packed {
    logic hit;
    reg_idx_t idx;
    logic [7:0] mask;
  } reg_dec_t;
endpackage

/* rtl/pin_route_mux.sv */
// combinational steering of peripheral signals onto package pins
`timescale 1ns/1ns
`default_nettype none
module pin_route_mux (
  input wire port_routing_pkg::route_t route,
  input wire port_routing_pkg::pad_vec_t gpio_out,
  input wire port_routing_pkg::pad_vec_t gpio_oe,
  input wire port_routing_pkg::pad_vec_t pin_in,
  input wire port_routing_pkg::periph_out_t po,
  input wire logic first_serial_interface_enable,
  input wire logic transceiver_enable,
  input wire logic tx_data_bit,
  output port_routing_pkg::pad_vec_t pad_out,
  output port_routing_pkg::pad_vec_t pad_oe,
  output port_routing_pkg::periph_in_t pi
);
  import port_routing_pkg::*;

  // spare codes 101 and 111 fold onto the code below them; 010 and 011 fall back to internal
  function automatic link_mode_t link_mode(input logic [2:0] code);
    case (code)
      3'b001: link_mode = LINK_DIRECT;
      3'b100, 3'b101: link_mode = LINK_PROBE;
      3'b110, 3'b111: link_mode = LINK_CONFORM;
      default: link_mode = LINK_INTERNAL;
    endcase
  endfunction

  // later assignments win: link over can over i2c over second serial
  always_comb
  begin
    pad_out = gpio_out;
    pad_oe = gpio_oe;
    pi = '0;
    if (route.second_serial_route_select)
    begin
      pad_out.t[3] = po.second_serial_tx;
      pad_oe.t[3] = 1'b1;
      pi.second_serial_rx = pin_in.t[2];
    end
    else
    begin
      pad_out.t[1] = po.second_serial_tx;
      pad_oe.t[1] = 1'b1;
      pi.second_serial_rx = pin_in.t[0];
    end
    // i2c lines are open drain: only ever pull low
    if (route.i2c_route_select)
    begin
      pad_out.t[1:0] = 2'b00;
      pad_oe.t[1:0] = {po.i2c_clock_low, po.i2c_data_low};
      pi.i2c_data_line = pin_in.t[0];
      pi.i2c_clock_line = pin_in.t[1];
    end
    else
    begin
      pad_out.j = 2'b00;
      pad_oe.j = {po.i2c_clock_low, po.i2c_data_low};
      pi.i2c_data_line = pin_in.j[0];
      pi.i2c_clock_line = pin_in.j[1];
    end
    if (route.can_route_select)
    begin
      pi.can_rx_in = pin_in.j[0];
      pad_out.j[1] = po.can_tx_out;
      pad_oe.j[1] = 1'b1;
    end
    else
    begin
      pi.can_rx_in = pin_in.s[0];
      pad_out.s[2] = po.can_tx_out;
      pad_oe.s[2] = 1'b1;
    end
    pi.serial_rx_in = po.transceiver_rx_output;
    pi.transceiver_tx_input = po.serial_tx_out;
    unique case (link_mode(route.serial_lin_link_route))
      LINK_INTERNAL:
      begin
        pi.transceiver_tx_input = po.serial_tx_out;
      end
      LINK_DIRECT:
      begin
        pi.transceiver_tx_input = tx_data_bit;
      end
      LINK_PROBE:
      begin
        if (first_serial_interface_enable)
        begin
          pad_out.t[1] = po.serial_tx_out;
          pad_oe.t[1] = 1'b1;
        end
        if (transceiver_enable)
        begin
          pad_out.t[0] = po.transceiver_rx_output;
          pad_oe.t[0] = 1'b1;
        end
      end
      LINK_CONFORM:
      begin
        pi.serial_rx_in = pin_in.s[0];
        pi.transceiver_tx_input = pin_in.t[1];
        if (first_serial_interface_enable)
        begin
          pad_out.s[1] = po.serial_tx_out;
          pad_oe.s[1] = 1'b1;
        end
        if (transceiver_enable)
        begin
          pad_out.t[0] = po.transceiver_rx_output;
          pad_oe.t[0] = 1'b1;
          pad_out.s[3] = po.transceiver_dominant_signal;
          pad_oe.s[3] = 1'b1;
        end
      end
    endcase
  end
endmodule
`default_nettype wire

/* rtl/port_routing_and_pin_regs.sv */
// port register bank, routing register and pad output stage
`timescale 1ns/1ns
`default_nettype none
`include "port_routing_params.svh"
module port_routing_and_pin_regs #(
  parameter int NUM_REGS = 28
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic special_mode,
  input wire logic first_serial_interface_enable,
  input wire logic transceiver_enable,
  input wire port_routing_pkg::pad_vec_t pin_in,
  input wire logic port_l_in,
  input wire logic [7:0] overcurrent_in,
  input wire port_routing_pkg::periph_out_t periph_out,
  output port_routing_pkg::pad_vec_t pin_out,
  output port_routing_pkg::pad_vec_t pin_oe,
  output port_routing_pkg::periph_in_t periph_in,
  output logic irq
);
  import port_routing_pkg::*;

  // storage table for every plain read/write port register
  function automatic reg_dec_t ent(input reg_idx_t i, input logic [7:0] m);
    reg_dec_t d;
    d.hit = 1'b1;
    d.idx = i;
    d.mask = m;
    return d;
  endfunction

  function automatic reg_dec_t decode(input logic [`ADDR_W-1:0] a);
    reg_dec_t d;
    d = '{hit: 1'b0, idx: RI_S_OUT, mask: 8'h00};
    case (a)
      `OFS_S_OUT: d = ent(RI_S_OUT, `MASK_S);
      `OFS_S_DIR: d = ent(RI_S_DIR, `MASK_S);
      `OFS_S_PULL_EN: d = ent(RI_S_PULL_EN, `MASK_S);
      `OFS_S_PULL_POL: d = ent(RI_S_PULL_POL, `MASK_S);
      `OFS_S_IRQ_EN: d = ent(RI_S_IRQ_EN, `MASK_S);
      `OFS_S_IRQ_FLAG: d = ent(RI_S_IRQ_FLAG, `MASK_S);
      `OFS_S_OD: d = ent(RI_S_OD, `MASK_S);
      `OFS_P_OUT: d = ent(RI_P_OUT, `MASK_P);
      `OFS_P_DIR: d = ent(RI_P_DIR, `MASK_P);
      `OFS_P_PULL_EN: d = ent(RI_P_PULL_EN, `MASK_P);
      `OFS_P_PULL_POL: d = ent(RI_P_PULL_POL, `MASK_P);
      `OFS_P_IRQ_EN: d = ent(RI_P_IRQ_EN, `MASK_P);
      `OFS_P_IRQ_FLAG: d = ent(RI_P_IRQ_FLAG, `MASK_P);
      `OFS_P_OCP_EN: d = ent(RI_P_OCP_EN, `MASK_OC);
      `OFS_P_OC_IE: d = ent(RI_P_OC_IE, `MASK_OC);
      `OFS_P_OC_FLAG: d = ent(RI_P_OC_FLAG, `MASK_OC);
      `OFS_P_RDR: d = ent(RI_P_RDR, `MASK_OC);
      `OFS_J_OUT: d = ent(RI_J_OUT, `MASK_J);
      `OFS_J_DIR: d = ent(RI_J_DIR, `MASK_J);
      `OFS_J_PULL_EN: d = ent(RI_J_PULL_EN, `MASK_J);
      `OFS_J_PULL_POL: d = ent(RI_J_PULL_POL, `MASK_J);
      `OFS_J_OD: d = ent(RI_J_OD, `MASK_J);
      `OFS_L_PULL_POL: d = ent(RI_L_PULL_POL, `MASK_L);
      `OFS_L_IRQ_EN: d = ent(RI_L_IRQ_EN, `MASK_L);
      `OFS_L_IRQ_FLAG: d = ent(RI_L_IRQ_FLAG, `MASK_L);
      `OFS_L_DIEN: d = ent(RI_L_DIEN, `MASK_L);
      `OFS_L_PORT_L_TEST_ACCESS_CONTROL: d = ent(RI_L_PORT_L_TEST_ACCESS_CONTROL, `MASK_PORT_L_TEST_ACCESS_CONTROL);
      `OFS_L_PORT_L_INPUT_ROUTE: d = ent(RI_L_PORT_L_INPUT_ROUTE, `MASK_PORT_L_INPUT_ROUTE);
      default: d.hit = 1'b0;
    endcase
    return d;
  endfunction

  // flag registers clear by writing one, everything else stores
  function automatic logic is_flag(input reg_idx_t i);
    return (i == RI_S_IRQ_FLAG) || (i == RI_P_IRQ_FLAG) ||
      (i == RI_P_OC_FLAG) || (i == RI_L_IRQ_FLAG);
  endfunction

  // edge selected by pull polarity: one means rising
  function automatic logic [7:0] edges(input logic [7:0] now,
    input logic [7:0] was, input logic [7:0] pol);
    return (pol & now & ~was) | (~pol & ~now & was);
  endfunction

  // state first, then the combinational helpers
  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] regs_d [NUM_REGS];
  route_t route_q;
  logic lock_q;
  logic txbit_q;
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic [7:0] mask_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic [3:0] in_s_q;
  logic [7:0] in_p_q;
  logic [1:0] in_j_q;
  logic in_l_q;
  pad_vec_t pin_out_q;
  pad_vec_t pin_oe_q;
  periph_in_t periph_in_q;
  reg_dec_t wdec;
  reg_dec_t rdec;
  logic [7:0] s_set;
  logic [7:0] p_set;
  logic [7:0] l_set;
  logic [7:0] oc_set;
  logic [7:0] ev;
  logic route_wr;
  logic refused;
  logic [7:0] rd_val;
  logic l_level;
  pad_vec_t gpio_out;
  pad_vec_t gpio_oe;
  pad_vec_t pad_out_c;
  pad_vec_t pad_oe_c;
  periph_in_t periph_in_c;

  // one decoder per direction keeps the two paths independent
  assign wdec = decode(addr);
  assign rdec = decode(addr);
  // port l reads low while its digital input is switched off
  // keeps a floating analog pin from toggling the edge detector
  assign l_level = port_l_in & regs_q[RI_L_DIEN][0];

  // pin levels sampled once per clock for reads and edge detection
  // inputs are taken as synchronous, so no extra synchroniser stage
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      in_s_q <= 4'h0;
      in_p_q <= 8'h00;
      in_j_q <= 2'b00;
      in_l_q <= 1'b0;
    end
    else
    begin
      in_s_q <= pin_in.s;
      in_p_q <= pin_in.p;
      in_j_q <= pin_in.j;
      in_l_q <= l_level;
    end
  end

  // hardware-set flag bits, before masking with the reserved layout
  always_comb
  begin
    s_set = edges({4'h0, pin_in.s}, {4'h0, in_s_q}, regs_q[RI_S_PULL_POL]);
    p_set = edges(pin_in.p, in_p_q, regs_q[RI_P_PULL_POL]);
    l_set = edges({7'h00, l_level}, {7'h00, in_l_q}, regs_q[RI_L_PULL_POL]);
    oc_set = overcurrent_in & regs_q[RI_P_OCP_EN];
  end

  // register writes; a flag being set in the clear cycle stays set
  // so a fresh event is never lost to a late clear
  always_comb
  begin
    regs_d = regs_q;
    if (wr && wdec.hit)
    begin
      if (is_flag(wdec.idx))
        regs_d[wdec.idx] = regs_q[wdec.idx] & ~(wdata & wdec.mask);
      else
        regs_d[wdec.idx] = wdata & wdec.mask;
    end
    regs_d[RI_S_IRQ_FLAG] = regs_d[RI_S_IRQ_FLAG] | (s_set & `MASK_S);
    regs_d[RI_P_IRQ_FLAG] = regs_d[RI_P_IRQ_FLAG] | (p_set & `MASK_P);
    regs_d[RI_P_OC_FLAG] = regs_d[RI_P_OC_FLAG] | (oc_set & `MASK_OC);
    regs_d[RI_L_IRQ_FLAG] = regs_d[RI_L_IRQ_FLAG] | (l_set & `MASK_L);
  end

  // register file, every entry cleared by reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_q[i] <= `RST_PORT;
    end
    else
    begin
      regs_q <= regs_d;
    end
  end

  // routing register: one write in normal mode, any in special mode
  assign route_wr = wr && (addr == `OFS_ROUTE);
  assign refused = route_wr && lock_q && !special_mode;

  // only a normal-mode write sets the lock; special mode never locks
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      route_q <= `RST_ROUTE;
      lock_q <= 1'b0;
    end
    else if (route_wr && (special_mode || !lock_q))
    begin
      route_q <= wdata & `MASK_ROUTE;
      lock_q <= lock_q | !special_mode;
    end
  end

  // direct-control bit for the transceiver transmit input
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      txbit_q <= 1'b0;
    else if (wr && (addr == `OFS_TXBIT))
      txbit_q <= wdata[0];
  end

  // events for the summary status: enabled edges, overcurrent, refusals
  always_comb
  begin
    ev = 8'h00;
    ev[`INT_REFUSED] = refused;
    ev[`INT_PORT_S] = |(s_set & regs_q[RI_S_IRQ_EN] & `MASK_S);
    ev[`INT_PORT_P] = |(p_set & regs_q[RI_P_IRQ_EN]);
    ev[`INT_PORT_L] = |(l_set & regs_q[RI_L_IRQ_EN] & `MASK_L);
    ev[`INT_OVERCUR] = |(oc_set & regs_q[RI_P_OC_IE] & `MASK_OC);
    stat_d = stat_q;
    if (wr && (addr == `OFS_INT_STAT))
      stat_d = stat_q & ~(wdata & `MASK_INT);
    stat_d = stat_d | ev;
  end

  // status bits stay until software writes a one
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      stat_q <= `RST_INT;
    else
      stat_q <= stat_d;
  end

  // mask register shares the status layout
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mask_q <= `RST_INT;
    else if (wr && (addr == `OFS_INT_MASK))
      mask_q <= wdata & `MASK_INT;
  end

  // level interrupt, one cycle behind the status it reflects
  // registering it keeps the pin free of glitches while status settles
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_q & mask_q);
  end

  // read data stands only in the cycle after the strobe
  always_comb
  begin
    case (addr)
      `OFS_S_IN: rd_val = {4'h0, in_s_q};
      `OFS_P_IN: rd_val = in_p_q;
      `OFS_J_IN: rd_val = {6'h00, in_j_q};
      `OFS_L_IN: rd_val = {7'h00, in_l_q};
      `OFS_ROUTE: rd_val = route_q;
      `OFS_INT_STAT: rd_val = stat_q;
      `OFS_INT_MASK: rd_val = mask_q;
      `OFS_TXBIT: rd_val = {7'h00, txbit_q};
      default: rd_val = rdec.hit ? regs_q[rdec.idx] : 8'h00;
    endcase
  end

  // zero between slots keeps stale data off the bus
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 8'h00;
    else if (rd)
      rdata_q <= rd_val;
    else
      rdata_q <= 8'h00;
  end

  // general purpose drive; open drain drops the enable on a one
  // port t has no general purpose drive in this block
  always_comb
  begin
    gpio_out = '0;
    gpio_oe = '0;
    gpio_out.s = regs_q[RI_S_OUT][3:0];
    gpio_oe.s = regs_q[RI_S_DIR][3:0] &
      ~(regs_q[RI_S_OD][3:0] & regs_q[RI_S_OUT][3:0]);
    gpio_out.p = regs_q[RI_P_OUT];
    gpio_oe.p = regs_q[RI_P_DIR];
    gpio_out.j = regs_q[RI_J_OUT][1:0];
    gpio_oe.j = regs_q[RI_J_DIR][1:0] &
      ~(regs_q[RI_J_OD][1:0] & regs_q[RI_J_OUT][1:0]);
  end

  pin_route_mux u_mux (
    .route(route_q),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe),
    .pin_in(pin_in),
    .po(periph_out),
    .first_serial_interface_enable(first_serial_interface_enable),
    .transceiver_enable(transceiver_enable),
    .tx_data_bit(txbit_q),
    .pad_out(pad_out_c),
    .pad_oe(pad_oe_c),
    .pi(periph_in_c)
  );

  // pad stage registered so every pin and peripheral input is a flop
  // costs one cycle of latency on every routed path
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      periph_in_q <= '0;
    end
    else
    begin
      pin_out_q <= pad_out_c;
      pin_oe_q <= pad_oe_c;
      periph_in_q <= periph_in_c;
    end
  end

  // outputs come straight from the flops above
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign periph_in = periph_in_q;
  assign rdata = rdata_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

/* testbench/far_side_model.sv */
// peripheral controllers and pad wiring around the routing block
`timescale 1ns/1ns
`default_nettype none
module far_side_model (
  input wire logic clk,
  input wire logic run,
  input wire port_routing_pkg::periph_out_t po_set,
  input wire port_routing_pkg::pad_vec_t ext_level,
  input wire port_routing_pkg::pad_vec_t pin_out,
  input wire port_routing_pkg::pad_vec_t pin_oe,
  output var port_routing_pkg::periph_out_t periph_out,
  output var port_routing_pkg::pad_vec_t pin_in
);
  import port_routing_pkg::*;
  // controllers move after the edge; running pattern exercises every path
  always_ff @(posedge clk)
  begin
    periph_out <= run ? periph_out_t'(periph_out + 7'h01) : po_set;
  end
  // a driven pad shows its driver, else the level the outside holds
  assign pin_in = pad_vec_t'((pin_out & pin_oe) | (ext_level & ~pin_oe));
endmodule
`default_nettype wire

/* testbench/port_routing_and_pin_regs_bench.sv */
// scenario bench for the port routing block
`timescale 1ns/1ns
`default_nettype none
`include "port_routing_params.svh"
module port_routing_and_pin_regs_bench;
  import port_routing_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [`ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic special_mode = 1'b0;
  logic first_serial_interface_enable = 1'b0;
  logic transceiver_enable = 1'b0;
  logic port_l_in = 1'b0;
  logic [7:0] overcurrent_in = 8'h00;
  logic run = 1'b0;
  periph_out_t po_set = '0;
  pad_vec_t ext_level = '0;
  logic [7:0] rdata;
  periph_out_t periph_out;
  pad_vec_t pin_in;
  pad_vec_t pin_out;
  pad_vec_t pin_oe;
  periph_in_t periph_in;
  logic irq;
  int n_fail = 0;
  int comparisons = 0;
  port_routing_and_pin_regs i_port_routing_and_pin_regs (
    .clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .special_mode, .first_serial_interface_enable,
    .transceiver_enable, .pin_in, .port_l_in, .overcurrent_in, .periph_out,
    .pin_out, .pin_oe, .periph_in, .irq
  );
  far_side_model i_far_side_model (
    .clk, .run, .po_set, .ext_level, .pin_out, .pin_oe, .periph_out, .pin_in
  );
  // 250 MHz clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one idle cycle after each write, so the strobe is never set twice in a step
  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [9:0] a, input logic [7:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic irqchk(input logic e);
    #1;
    chk(irq, e);
    @(posedge clk);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask
  // link-side pins and transceiver/serial inputs, driven levels only
  function automatic logic [9:0] link_view;
    pad_vec_t d;
    d = pad_vec_t'(pin_out & pin_oe);
    return {pin_oe.s[1], pin_oe.s[3], pin_oe.t[1], pin_oe.t[0], d.s[1], d.s[3], d.t[1],
      d.t[0], periph_in.transceiver_tx_input, periph_in.serial_rx_in};
  endfunction
  task automatic t_regs;
    logic [9:0] a [6] = '{`OFS_S_OUT, `OFS_P_OUT, `OFS_J_DIR, `OFS_P_OCP_EN, `OFS_L_PORT_L_TEST_ACCESS_CONTROL, 10'h2d5};
    logic [7:0] m [6] = '{8'h0f, 8'hff, 8'h03, 8'haa, 8'hf8, 8'h00};
    ext_level.p <= 8'h5a;
    rchk(`OFS_ROUTE, 8'h00);
    foreach (a[i])
    begin
      wreg(a[i], 8'hff);
      rchk(a[i], m[i]);
      wreg(a[i], 8'h00);
    end
    wreg(`OFS_P_IN, 8'h00);
    rchk(`OFS_P_IN, 8'h5a);
  endtask
  task automatic t_lock;
    wreg(`OFS_INT_MASK, 8'h01);
    wreg(`OFS_ROUTE, 8'h38);
    rchk(`OFS_ROUTE, 8'h38);
    wreg(`OFS_ROUTE, 8'hc7);
    rchk(`OFS_ROUTE, 8'h38);
    rchk(`OFS_INT_STAT, 8'h01);
    irqchk(1'b1);
    wreg(`OFS_INT_MASK, 8'h00);
    irqchk(1'b0);
    wreg(`OFS_INT_STAT, 8'h01);
    rchk(`OFS_INT_STAT, 8'h00);
    special_mode <= 1'b1;
    wreg(`OFS_ROUTE, 8'h06);
    wreg(`OFS_ROUTE, 8'h01);
    rchk(`OFS_ROUTE, 8'h01);
    special_mode <= 1'b0;
    wreg(`OFS_ROUTE, 8'h02);
    rchk(`OFS_ROUTE, 8'h01);
    do_reset;
    rchk(`OFS_ROUTE, 8'h00);
    wreg(`OFS_ROUTE, 8'h10);
    rchk(`OFS_ROUTE, 8'h10);
  endtask
  task automatic t_pins;
    logic [9:0] e [8] = '{10'h003, 10'h001, 10'h003, 10'h003, 10'h0cf, 10'h0cf, 10'h374, 10'h374};
    logic [5:0] v;
    run <= 1'b0;
    po_set <= 7'h67;
    special_mode <= 1'b1;
    first_serial_interface_enable <= 1'b1;
    transceiver_enable <= 1'b1;
    ext_level.j <= 2'b01;
    wreg(`OFS_TXBIT, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wreg(`OFS_ROUTE, 8'h08 | 8'(c));
      settle;
      chk(link_view(), e[c]);
      @(posedge clk);
    end
    first_serial_interface_enable <= 1'b0;
    transceiver_enable <= 1'b0;
    wreg(`OFS_ROUTE, 8'h0c);
    settle;
    chk(link_view(), 10'h003);
    @(posedge clk);
    first_serial_interface_enable <= 1'b1;
    wreg(`OFS_ROUTE, 8'h0e);
    settle;
    chk(link_view(), 10'h220);
    @(posedge clk);
    wreg(`OFS_ROUTE, 8'h38);
    settle;
    v = {pin_oe.j[1], pin_out.j[1], pin_oe.t[0], pin_oe.t[1], pin_oe.t[3], periph_in.can_rx_in};
    chk(v, 6'b111011);
    @(posedge clk);
    wreg(`OFS_ROUTE, 8'h00);
    settle;
    v = {pin_oe.s[2], pin_out.s[2], pin_oe.j[0], pin_oe.j[1], pin_oe.t[1], periph_in.can_rx_in};
    chk(v, 6'b111010);
    @(posedge clk);
  endtask
  // rising edge on port s pin 0 raises a flag, status and the interrupt line
  task automatic t_irq;
    wreg(`OFS_S_IRQ_FLAG, 8'h0f);
    wreg(`OFS_S_PULL_POL, 8'h01);
    wreg(`OFS_S_IRQ_EN, 8'h01);
    wreg(`OFS_INT_MASK, 8'h02);
    ext_level.s[0] <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(`OFS_S_IRQ_FLAG, 8'h01);
    rchk(`OFS_INT_STAT, 8'h02);
    irqchk(1'b1);
    wreg(`OFS_S_IRQ_FLAG, 8'h01);
    wreg(`OFS_INT_STAT, 8'h02);
    rchk(`OFS_S_IRQ_FLAG, 8'h00);
    irqchk(1'b0);
    overcurrent_in <= 8'h03;
    wreg(`OFS_P_OCP_EN, 8'h03);
    wreg(`OFS_P_OC_FLAG, 8'h00);
    rchk(`OFS_P_OC_FLAG, 8'h02);
  endtask
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, far beyond the roughly two hundred cycles the scenarios need
  initial
  begin
    #40000;
    n_fail++;
    end_sim;
  end
  initial
  begin
    do_reset;
    run <= 1'b1;
    t_regs;
    t_lock;
    t_pins;
    t_irq;
    end_sim;
  end
endmodule
`default_nettype wire

/* testbench/port_routing_checker.sv */
// concurrent checks on the routing block ports
`timescale 1ns/1ns
`default_nettype none
`include "port_routing_params.svh"
module port_routing_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic special_mode,
  input wire port_routing_pkg::pad_vec_t pin_in,
  input wire port_routing_pkg::periph_out_t periph_out,
  input wire port_routing_pkg::pad_vec_t pin_out,
  input wire port_routing_pkg::pad_vec_t pin_oe,
  input wire port_routing_pkg::periph_in_t periph_in
);
  import port_routing_pkg::*;
  logic [5:0] route_q;
  logic locked_q;
  logic alive_q;
  // shadow routing value; alive_q skips the edge where outputs still hold reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      route_q <= 6'h00;
      locked_q <= 1'b0;
      alive_q <= 1'b0;
    end
    else
    begin
      alive_q <= 1'b1;
      if (wr && addr == `OFS_ROUTE && (special_mode || !locked_q))
      begin
        route_q <= wdata[5:0];
        locked_q <= locked_q | !special_mode;
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  a_route_readback: assert property (
    rd && addr == `OFS_ROUTE |=> rdata == {2'b00, $past(route_q)})
    else $error("routing readback wrong");
  a_can_tx_low: assert property (alive_q && !$past(route_q[5]) |->
    pin_oe.s[2] && pin_out.s[2] == $past(periph_out.can_tx_out))
    else $error("can transmit not on port s pin 2");
  a_can_tx_alt: assert property (alive_q && $past(route_q[5]) |->
    pin_oe.j[1] && pin_out.j[1] == $past(periph_out.can_tx_out))
    else $error("can transmit not on port j pin 1");
  a_can_rx_pick: assert property (alive_q |->
    periph_in.can_rx_in == $past(route_q[5] ? pin_in.j[0] : pin_in.s[0]))
    else $error("can receive from wrong pin");
  a_i2c_data_alt: assert property (alive_q && $past(route_q[4] && !route_q[2]) |->
    !pin_out.t[0] && pin_oe.t[0] == $past(periph_out.i2c_data_low))
    else $error("i2c data not on port t pin 0");
  a_serial2_tx_alt: assert property (alive_q && $past(route_q[3]) |->
    pin_oe.t[3] && pin_out.t[3] == $past(periph_out.second_serial_tx))
    else $error("second serial transmit not on port t pin 5");
  a_serial2_rx_pick: assert property (alive_q |->
    periph_in.second_serial_rx == $past(route_q[3] ? pin_in.t[2] : pin_in.t[0]))
    else $error("second serial receive from wrong pin");
  a_link_internal: assert property (alive_q && $past(route_q[2:0] == 3'b000) |->
    periph_in.transceiver_tx_input == $past(periph_out.serial_tx_out) &&
    periph_in.serial_rx_in == $past(periph_out.transceiver_rx_output))
    else $error("internal link broken");
endmodule
bind port_routing_and_pin_regs port_routing_checker i_port_routing_checker (
  .clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .special_mode,
  .pin_in, .periph_out, .pin_out, .pin_oe, .periph_in
);
`default_nettype wire
